// ### verilog/dsacc_mem.sv
// Data-space end: working registers, byte-lane memory, pin port, trap
`timescale 1ns/1ps
`default_nettype none
module dsacc_mem #(
   parameter int RAM_WORDS = dsacc_pkg::RAM_WORDS,
   parameter int CFG_STYLE_SELECT = 0,
   parameter logic [15:0] PORT_ADDR = 16'h02c0
) (
   input wire logic mclk,
   input wire logic rst_n,
   dsacc_if.mem bus,
   output logic [15:0] wreg0_view,
   output logic trap_pending
);
   // Refuse a memory that does not fit between 0800h and the top of the space
   if (RAM_WORDS < 2 || RAM_WORDS > 31744) begin : g_bad_ram
      $error("RAM_WORDS out of range");
   end
   // Only the two configuration styles are decoded
   if (CFG_STYLE_SELECT < 0 || CFG_STYLE_SELECT > 1) begin : g_bad_style
      $error("CFG_STYLE_SELECT must be 0 or 1");
   end

   localparam int RAM_AW = $clog2(RAM_WORDS);
   localparam logic [15:0] RAM_BASE = 16'h0800;

   typedef struct packed {
      logic [dsacc_pkg::WREG_N-1:0][15:0] wreg;
      logic done;
      logic [15:0] rdata;
      logic [15:0] ea;
      logic trap;
      logic [15:0] trap_addr;
      logic pend;
      logic [15:0] pin_s1;
      logic [15:0] pin_s2;
      logic [15:0] apc;
      logic [15:0] pas;
   } dsacc_mem_st_t;

   dsacc_mem_st_t st, next_st;
   logic [7:0] ram_lo [RAM_WORDS];
   logic [7:0] ram_hi [RAM_WORDS];
   logic lo_we, hi_we;
   logic [RAM_AW-1:0] ram_idx;
   logic [15:0] addr;
   logic [15:0] word;
   logic [15:0] pin_digital;
   logic is_ram, misalign, in_wreg;

   // Effective address by addressing mode
   always_comb begin
      case (bus.mode)
         dsacc_pkg::DSACC_MODE_NEAR_DIRECT: addr = bus.direct_addr & dsacc_pkg::NEAR_TOP;
         dsacc_pkg::DSACC_MODE_FULL_DIRECT: addr = bus.direct_addr;
         default: addr = st.wreg[bus.ptr_reg];
      endcase
   end

   assign is_ram = (addr > dsacc_pkg::SFR_TOP) &&
      (32'(addr - RAM_BASE) < 32'(2 * RAM_WORDS));
   assign in_wreg = addr <= dsacc_pkg::WREG_AREA_TOP;
   assign ram_idx = RAM_AW'((addr - RAM_BASE) >> 1);
   assign misalign = !bus.byte_op && addr[0];
   // Analog pins read zero; polarity per configuration style
   assign pin_digital = (CFG_STYLE_SELECT != 0) ? (st.pin_s2 & ~st.pas)
      : (st.pin_s2 & st.apc);

   // Whole word fetch for the addressed location
   always_comb begin
      if (in_wreg) begin
         word = st.wreg[addr[4:1]];
      end else if (is_ram) begin
         word = {ram_hi[ram_idx], ram_lo[ram_idx]};
      end else if (addr == PORT_ADDR) begin
         word = pin_digital;
      end else begin
         word = dsacc_pkg::ZERO_WORD;
      end
   end

   // Lane strobes, write suppressed on misalignment
   always_comb begin
      lo_we = 1'b0;
      hi_we = 1'b0;
      if (bus.req && bus.op == dsacc_pkg::DSACC_OP_WRITE && is_ram && !misalign) begin
         lo_we = !bus.byte_op || !addr[0];
         hi_we = !bus.byte_op || addr[0];
      end
   end

   // Byte-lane memory
   always_ff @(posedge mclk) begin
      if (lo_we) begin
         ram_lo[ram_idx] <= bus.wdata[7:0];
      end
      if (hi_we) begin
         ram_hi[ram_idx] <= bus.byte_op ? bus.wdata[7:0] : bus.wdata[15:8];
      end
   end

   // Next state
   always_comb begin
      logic [7:0] sel;
      logic [15:0] cur;
      sel = addr[0] ? word[15:8] : word[7:0];
      cur = st.wreg[bus.dst_reg];
      next_st = st;
      next_st.done = 1'b0;
      next_st.trap = 1'b0;
      next_st.pin_s1 = bus.pin_in;
      next_st.pin_s2 = st.pin_s1;
      if (bus.cfg_we) begin
         next_st.apc = bus.analog_pin_config_reg;
         next_st.pas = bus.port_analog_select_reg;
      end
      if (bus.req) begin
         next_st.done = 1'b1;
         next_st.ea = addr;
         case (bus.op)
            dsacc_pkg::DSACC_OP_READ: begin
               next_st.rdata = bus.byte_op ? {8'h00, sel} : word;
               if (bus.byte_op) begin
                  next_st.wreg[bus.dst_reg] = {cur[15:8], sel};
               end else begin
                  next_st.wreg[bus.dst_reg] = word;
               end
            end
            dsacc_pkg::DSACC_OP_WRITE: begin
               if (in_wreg && !misalign) begin
                  if (bus.byte_op && addr[0]) begin
                     next_st.wreg[addr[4:1]][15:8] = bus.wdata[7:0];
                  end else if (bus.byte_op) begin
                     next_st.wreg[addr[4:1]][7:0] = bus.wdata[7:0];
                  end else begin
                     next_st.wreg[addr[4:1]] = bus.wdata;
                  end
               end
               next_st.rdata = word;
            end
            dsacc_pkg::DSACC_OP_SIGN_EXT: begin
               next_st.wreg[bus.dst_reg] = {{8{cur[7]}}, cur[7:0]};
               next_st.rdata = {{8{cur[7]}}, cur[7:0]};
            end
            dsacc_pkg::DSACC_OP_ZERO_EXT: begin
               next_st.wreg[bus.dst_reg] = {8'h00, cur[7:0]};
               next_st.rdata = {8'h00, cur[7:0]};
            end
            default: next_st.rdata = st.rdata;
         endcase
         if ((bus.op == dsacc_pkg::DSACC_OP_READ || bus.op == dsacc_pkg::DSACC_OP_WRITE)
               && misalign) begin
            next_st.trap = 1'b1;
            next_st.trap_addr = addr;
            next_st.pend = 1'b1;
         end
         if (bus.mode == dsacc_pkg::DSACC_MODE_POST_INC &&
               bus.op != dsacc_pkg::DSACC_OP_SIGN_EXT &&
               bus.op != dsacc_pkg::DSACC_OP_ZERO_EXT) begin
            next_st.wreg[bus.ptr_reg] = st.wreg[bus.ptr_reg] +
               (bus.byte_op ? dsacc_pkg::STEP_BYTE : dsacc_pkg::STEP_WORD);
         end
      end else if (st.pend) begin
         next_st.pend = 1'b0;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.apc <= 16'hffff;
      end else begin
         st <= next_st;
      end
   end

   assign bus.done = st.done;
   assign bus.rdata = st.rdata;
   assign bus.ea = st.ea;
   assign bus.addr_trap = st.trap;
   assign bus.trap_addr = st.trap_addr;
   assign wreg0_view = st.wreg[0];
   assign trap_pending = st.pend;
endmodule : dsacc_mem
`default_nettype wire

// ### verilog/dsacc_pkg.sv
// Package of constants and types for the data-space byte/word access block
package dsacc_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   localparam int NEAR_W = 13;
   localparam int WREG_N = 16;
   localparam int WREG_IDX_W = 4;
   localparam logic [15:0] NEAR_TOP = 16'h1fff;
   localparam logic [15:0] SFR_TOP = 16'h07ff;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] WREG_RESET = 16'h0000;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   // Working registers appear at the bottom of the special register area
   localparam logic [15:0] WREG_AREA_TOP = 16'h001f;
   localparam int RAM_WORDS = 2048;
   localparam int PIN_N = 16;

   // Operations issued by the execution unit
   typedef enum logic [2:0] {
      DSACC_OP_NONE,
      DSACC_OP_READ,
      DSACC_OP_WRITE,
      DSACC_OP_SIGN_EXT,
      DSACC_OP_ZERO_EXT
   } dsacc_op_t;

   // Addressing modes of an access
   typedef enum logic [1:0] {
      DSACC_MODE_INDIRECT,
      DSACC_MODE_POST_INC,
      DSACC_MODE_NEAR_DIRECT,
      DSACC_MODE_FULL_DIRECT
   } dsacc_mode_t;
endpackage : dsacc_pkg

// ### verilog/dsacc_if.sv
// Interface joining the execution unit end and the data-space end
`timescale 1ns/1ps
`default_nettype none
interface dsacc_if;
   logic req;
   dsacc_pkg::dsacc_op_t op;
   dsacc_pkg::dsacc_mode_t mode;
   logic byte_op;
   logic [3:0] ptr_reg;
   logic [3:0] dst_reg;
   logic [15:0] direct_addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   logic [15:0] ea;
   logic addr_trap;
   logic [15:0] trap_addr;
   logic [15:0] pin_in;
   logic [15:0] analog_pin_config_reg;
   logic [15:0] port_analog_select_reg;
   logic cfg_we;

   modport core (output req, op, mode, byte_op, ptr_reg, dst_reg, direct_addr, wdata,
      cfg_we, analog_pin_config_reg, port_analog_select_reg,
      input done, rdata, ea, addr_trap, trap_addr);
   modport mem (input req, op, mode, byte_op, ptr_reg, dst_reg, direct_addr, wdata,
      cfg_we, analog_pin_config_reg, port_analog_select_reg, pin_in,
      output done, rdata, ea, addr_trap, trap_addr);
endinterface : dsacc_if
`default_nettype wire

// ### verilog/dsacc_core.sv
// Execution-unit end: issues accesses, sets pin configuration for debug
`timescale 1ns/1ps
`default_nettype none
module dsacc_core (
   input wire logic mclk,
   input wire logic rst_n,
   dsacc_if.core bus,
   input wire logic debug_mode,
   input wire logic [15:0] debug_pair_mask,
   input wire logic [15:0] app_analog_mask,
   input wire logic start,
   input wire dsacc_pkg::dsacc_op_t op,
   input wire dsacc_pkg::dsacc_mode_t mode,
   input wire logic byte_op,
   input wire logic [3:0] ptr_reg,
   input wire logic [3:0] dst_reg,
   input wire logic [15:0] direct_addr,
   input wire logic [15:0] wdata,
   output logic busy,
   output logic [15:0] result,
   output logic trapped
);
   typedef enum logic [1:0] {DSACC_S_CFG, DSACC_S_IDLE, DSACC_S_WAIT} dsacc_core_state_t;
   typedef struct packed {
      dsacc_core_state_t state;
      logic req;
      dsacc_pkg::dsacc_op_t op;
      dsacc_pkg::dsacc_mode_t mode;
      logic byte_op;
      logic [3:0] ptr_reg;
      logic [3:0] dst_reg;
      logic [15:0] direct_addr;
      logic [15:0] wdata;
      logic cfg_we;
      logic [15:0] apc;
      logic [15:0] pas;
      logic busy;
      logic [15:0] result;
      logic trapped;
   } dsacc_core_st_t;

   dsacc_core_st_t st, next_st;

   // Sequencer
   always_comb begin
      next_st = st;
      next_st.req = 1'b0;
      next_st.cfg_we = 1'b0;
      case (st.state)
         DSACC_S_CFG: begin
            // All pins digital when debugging, else app mask; debug pair kept digital
            next_st.apc = debug_mode ? 16'hffff : (~app_analog_mask | debug_pair_mask);
            next_st.pas = debug_mode ? 16'h0000 : (app_analog_mask & ~debug_pair_mask);
            next_st.cfg_we = 1'b1;
            next_st.state = DSACC_S_IDLE;
         end
         DSACC_S_IDLE: begin
            if (start) begin
               next_st.req = 1'b1;
               next_st.op = op;
               next_st.mode = mode;
               next_st.byte_op = byte_op;
               next_st.ptr_reg = ptr_reg;
               next_st.dst_reg = dst_reg;
               next_st.direct_addr = direct_addr;
               next_st.wdata = wdata;
               next_st.busy = 1'b1;
               next_st.state = DSACC_S_WAIT;
            end
         end
         DSACC_S_WAIT: begin
            if (bus.done) begin
               next_st.result = bus.rdata;
               next_st.trapped = bus.addr_trap;
               next_st.busy = 1'b0;
               next_st.state = DSACC_S_IDLE;
            end
         end
         default: next_st.state = DSACC_S_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.state <= DSACC_S_CFG;
      end else begin
         st <= next_st;
      end
   end

   assign bus.req = st.req;
   assign bus.op = st.op;
   assign bus.mode = st.mode;
   assign bus.byte_op = st.byte_op;
   assign bus.ptr_reg = st.ptr_reg;
   assign bus.dst_reg = st.dst_reg;
   assign bus.direct_addr = st.direct_addr;
   assign bus.wdata = st.wdata;
   assign bus.cfg_we = st.cfg_we;
   assign bus.analog_pin_config_reg = st.apc;
   assign bus.port_analog_select_reg = st.pas;
   assign busy = st.busy;
   assign result = st.result;
   assign trapped = st.trapped;
endmodule : dsacc_core
`default_nettype wire

// ### testbench/dsacc_chk.sv
// Assertions on the execution-unit to data-space interface
`timescale 1ns/1ps
`default_nettype none
module dsacc_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic req,
   input wire dsacc_pkg::dsacc_op_t op,
   input wire dsacc_pkg::dsacc_mode_t mode,
   input wire logic byte_op,
   input wire logic [15:0] direct_addr,
   input wire logic done,
   input wire logic [15:0] rdata,
   input wire logic [15:0] ea,
   input wire logic addr_trap,
   input wire logic [15:0] trap_addr
);
   // Request kinds
   wire rd = req && op == dsacc_pkg::DSACC_OP_READ;
   wire rw = rd || req && op == dsacc_pkg::DSACC_OP_WRITE;
   wire rdb = rd && byte_op;
   wire near = rw && mode == dsacc_pkg::DSACC_MODE_NEAR_DIRECT;
   wire full = rw && mode == dsacc_pkg::DSACC_MODE_FULL_DIRECT;
   wire pinc = rw && mode == dsacc_pkg::DSACC_MODE_POST_INC;
   // Unimplemented special register space, port excluded
   wire gap = ea inside {[16'h0020:16'h02bf], [16'h02c2:16'h07ff]};
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Handshake and alignment
   a_done_after_req: assert property (req |=> done && !req)
      else $error("done missing after request");
   a_done_has_cause: assert property (done |-> $past(req))
      else $error("done without request");
   a_trap_odd_word: assert property (done && $past(rw) |-> addr_trap == (ea[0] && !$past(byte_op)))
      else $error("trap does not match alignment");
   a_trap_with_done: assert property (addr_trap |-> done && $past(rw))
      else $error("trap outside a data access");
   a_trap_records: assert property (addr_trap |-> trap_addr == ea)
      else $error("trap address not recorded");
   // Lanes, reach and unimplemented reads
   a_byte_low_lane: assert property (done && $past(rdb) |-> rdata[15:8] == 8'h00)
      else $error("byte read high lane not zero");
   a_near_reach: assert property (done && $past(near) |-> ea == ($past(direct_addr) & 16'h1fff))
      else $error("near address wrong");
   a_full_reach: assert property (done && $past(full) |-> ea == $past(direct_addr))
      else $error("full address wrong");
   a_gap_reads_zero: assert property (done && $past(rd) && gap |-> rdata == 16'h0000)
      else $error("unimplemented address not zero");
   c_trap: cover property (addr_trap);
   c_post_inc: cover property (done && $past(pinc));
   c_byte_read: cover property (done && $past(rdb));
endmodule : dsacc_chk
`default_nettype wire

// ### testbench/tb_top.sv
// Bench joining the execution-unit end to the data-space end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Row: op, mode, byte flag, address, write data or expected read
   typedef struct packed {
      logic [2:0] op;
      logic [1:0] md;
      logic b;
      logic [15:0] a;
      logic [15:0] d;
   } dsacc_row_t;
   logic mclk, rst_n, debug_mode, start, byte_op, busy, trapped, trap_pending, pend_seen;
   logic [15:0] debug_pair_mask, app_analog_mask, direct_addr, wdata, result, wreg0_view, pins;
   logic [3:0] ptr_reg, dst_reg;
   dsacc_pkg::dsacc_op_t op;
   dsacc_pkg::dsacc_mode_t mode;
   int num_errors = 0;
   int compares = 0;
   // Ops 1 read 2 write 3 sign 4 zero; modes 1 post-inc 2 near 3 full
   dsacc_row_t rows[25] = '{
      '{3'h2,2'h3,1'h0,16'h0800,16'ha55a},
      '{3'h1,2'h3,1'h0,16'h0800,16'ha55a},
      '{3'h2,2'h3,1'h1,16'h0801,16'h00c3},
      '{3'h1,2'h3,1'h0,16'h0800,16'hc35a},
      '{3'h1,2'h3,1'h1,16'h0801,16'h00c3},
      '{3'h1,2'h3,1'h1,16'h0800,16'h005a},
      '{3'h2,2'h3,1'h0,16'h0002,16'h0800},
      '{3'h1,2'h1,1'h1,16'h0000,16'h005a},
      '{3'h1,2'h3,1'h0,16'h0002,16'h0801},
      '{3'h1,2'h1,1'h1,16'h0000,16'h00c3},
      '{3'h2,2'h3,1'h0,16'h0002,16'h0800},
      '{3'h1,2'h1,1'h0,16'h0000,16'hc35a},
      '{3'h1,2'h3,1'h0,16'h0002,16'h0802},
      '{3'h1,2'h2,1'h0,16'he800,16'hc35a},
      '{3'h1,2'h3,1'h0,16'h0400,16'h0000},
      '{3'h2,2'h3,1'h0,16'h0006,16'h1280},
      '{3'h1,2'h3,1'h1,16'h0801,16'h00c3},
      '{3'h1,2'h3,1'h0,16'h0006,16'h12c3},
      '{3'h3,2'h0,1'h0,16'h0000,16'h0000},
      '{3'h1,2'h3,1'h0,16'h0006,16'hffc3},
      '{3'h4,2'h0,1'h0,16'h0000,16'h0000},
      '{3'h1,2'h3,1'h0,16'h0006,16'h00c3},
      '{3'h2,2'h0,1'h0,16'h0000,16'h3c96},
      '{3'h1,2'h0,1'h0,16'h0000,16'h3c96},
      '{3'h2,2'h3,1'h0,16'h0000,16'h1234}
   };
   ////////////////////////////////////////////////////////////
   // Both ends and the checker on one interface
   dsacc_if dsacc_if_i ();
   assign dsacc_if_i.pin_in = pins;
   dsacc_core dsacc_core_i (.mclk, .rst_n, .bus(dsacc_if_i), .debug_mode, .debug_pair_mask,
      .app_analog_mask, .start, .op, .mode, .byte_op, .ptr_reg, .dst_reg, .direct_addr,
      .wdata, .busy, .result, .trapped);
   dsacc_mem dsacc_mem_i (.mclk, .rst_n, .bus(dsacc_if_i), .wreg0_view, .trap_pending);
   dsacc_chk dsacc_chk_i (.mclk, .rst_n, .req(dsacc_if_i.req), .op(dsacc_if_i.op),
      .mode(dsacc_if_i.mode), .byte_op(dsacc_if_i.byte_op),
      .direct_addr(dsacc_if_i.direct_addr), .done(dsacc_if_i.done),
      .rdata(dsacc_if_i.rdata), .ea(dsacc_if_i.ea), .addr_trap(dsacc_if_i.addr_trap),
      .trap_addr(dsacc_if_i.trap_addr));
   ////////////////////////////////////////////////////////////
   // Clock
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   // Compare and count
   task chk(input string n, input logic [33:0] s, e);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Verdict and end of run
   task conclude;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // One access from a falling edge, waits out the fixed spacing
   task acc(input logic [2:0] o, input logic [1:0] m, input logic b, input logic [15:0] a, w);
      int i;
      start = 1'h1;
      op = dsacc_pkg::dsacc_op_t'(o);
      mode = dsacc_pkg::dsacc_mode_t'(m);
      byte_op = b;
      direct_addr = a;
      wdata = w;
      @(negedge mclk);
      start = 1'h0;
      @(negedge mclk);
      // Pending trap stands only in the same cycle as done
      pend_seen = trap_pending;
      repeat (2) @(negedge mclk);
      for (i = 0; busy !== 1'h0 && i < 9; i++) @(negedge mclk);
      if (i == 9) begin
         num_errors++;
         $display("CHECK FAILED busy expected 0 seen 1");
         conclude();
      end
   endtask : acc
   // Reset with a pin set-up, then read the pin port
   task rst(input logic dbg, input logic [15:0] app, exp);
      rst_n = 1'h0;
      debug_mode = dbg;
      app_analog_mask = app;
      repeat (4) @(negedge mclk);
      rst_n = 1'h1;
      chk("reset", {busy, trapped, result, wreg0_view}, 34'h0_0000_0000);
      repeat (2) @(negedge mclk);
      acc(3'h1, 2'h3, 1'h0, 16'h02c0, 16'h0000);
      chk("port", result, exp);
      $display("test reset done");
   endtask : rst
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {start, byte_op, direct_addr, wdata} = '0;
      op = dsacc_pkg::DSACC_OP_NONE;
      mode = dsacc_pkg::DSACC_MODE_INDIRECT;
      ptr_reg = 4'h1;
      dst_reg = 4'h3;
      debug_pair_mask = 16'h0030;
      // All sixteen pins carry data, so none is left unused or floating
      pins = 16'h5aff;
      rst(1'h1, 16'h0000, 16'h5aff);
      foreach (rows[k]) begin
         acc(rows[k].op, rows[k].md, rows[k].b, rows[k].a, rows[k].d);
         if (rows[k].op == 3'h1)
            chk("table read", result, rows[k].d);
      end
      $display("test table done");
      chk("w0", wreg0_view, 16'h1234);
      acc(3'h2, 2'h3, 1'h0, 16'h0001, 16'hffff);
      chk("odd write", {trapped, pend_seen, wreg0_view}, 18'h3_1234);
      acc(3'h2, 2'h3, 1'h1, 16'h0001, 16'h0056);
      chk("lane write", {trapped, pend_seen, wreg0_view}, 18'h0_5634);
      acc(3'h2, 2'h3, 1'h0, 16'h0002, 16'h0801);
      acc(3'h1, 2'h1, 1'h0, 16'h0000, 16'h0000);
      chk("odd read", {trapped, pend_seen}, 2'h3);
      acc(3'h1, 2'h3, 1'h0, 16'h0002, 16'h0000);
      chk("pointer", result, 16'h0803);
      $display("test traps done");
      rst(1'h1, 16'h00f0, 16'h5aff);
      rst(1'h0, 16'h00f0, 16'h5a3f);
      rst(1'h0, 16'h00c0, 16'h5a3f);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
